// ---- test/issfs_ctl_model.sv ----
// controller model: drives readout and pixel array strobes
module issfs_ctl_model (
    input wire logic clk,
    output issfs_pkg::issfs_rd_t rd,
    output logic reset_strobe,
    output logic dual_slope_reset,
    output logic memory_boost_strobe,
    output logic sample_n
);
    timeunit 1ns;
    timeprecision 1ps;
    // idle levels: boost and sample are active low
    initial begin
        rd = '0;
        reset_strobe = 1'h0;
        dual_slope_reset = 1'h0;
        memory_boost_strobe = 1'h1;
        sample_n = 1'h1;
    end
    ////////////////////////////////////////////////////////////////
    // all changes land just after a falling edge, clear of the sampling edge;
    // the far side looks half a period after each launching edge, and this is
    // the phase to move when the output delay of a real part shifts
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc
    // sync outlasts its least width and encloses a line clock rise
    task automatic frame_start();
        rd.frame_sync = 1'h1;
        cyc(1);
        rd.line_clk = 1'h1;
        cyc(issfs_pkg::FSYNC_MIN_CYC + 1);
        rd = '0;
        cyc(3);
    endtask : frame_start
    task automatic line_step();
        rd.line_sync = 1'h0;
        rd.line_clk = 1'h1;
        cyc(2);
        rd.line_clk = 1'h0;
        cyc(3);
    endtask : line_step
    // row overhead wait of 200 ns before the first pixel
    task automatic line_start();
        cyc(40);
        rd.line_sync = 1'h1;
        cyc(1);
        rd.pix_clk = 1'h1;
        cyc(4);
    endtask : line_start
    task automatic pix_half();
        rd.pix_clk = ~rd.pix_clk;
        cyc(4);
    endtask : pix_half
    task automatic set_rst(input logic r, input logic d);
        reset_strobe = r;
        dual_slope_reset = d;
        cyc(3);
    endtask : set_rst
    // reset pulse, then a 2 us dual-slope pulse inside integration
    task automatic expose();
        set_rst(1'h1, 1'h0);
        set_rst(1'h0, 1'h1);
        cyc(400);
        set_rst(1'h0, 1'h0);
    endtask : expose
    // boost 5.5 us envelopes a 5 us sample; boost rises 250 ns after sample
    task automatic store();
        memory_boost_strobe = 1'h0;
        cyc(50);
        sample_n = 1'h0;
        cyc(1000);
        sample_n = 1'h1;
        cyc(50);
        memory_boost_strobe = 1'h1;
        cyc(3);
    endtask : store
endmodule : issfs_ctl_model

// ---- test/issfs_props.sv ----
// checker: port-level properties of the frame sequencer
module issfs_props (
    input wire logic clk,
    input wire logic rst_n,
    input wire issfs_pkg::issfs_cfg_t cfg,
    input wire logic cfg_load,
    input wire issfs_pkg::issfs_rd_t rd,
    input wire logic reset_strobe,
    input wire logic dual_slope_reset,
    input wire logic memory_boost_strobe,
    input wire logic sample_n,
    input wire issfs_pkg::issfs_sel_t sel,
    input wire issfs_pkg::issfs_rst_lvl_t pix_reset_level,
    input wire logic readout_enable,
    input wire logic integrating
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////
    // loaded word, so expectations follow cfg_load and ignore stray cfg changes
    issfs_pkg::issfs_cfg_t cfg_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_q <= '0;
        end else if (cfg_load) begin
            cfg_q <= cfg;
        end
    end
    ////////////////////////////////////////////////////////////////
    a_sync_loads_start:
        assert property (rd.frame_sync |-> ##2 sel.line == {cfg_q.y_start, 1'h0}) else $error("bad start line");
    a_line_step_one:
        assert property ($rose(rd.line_clk) && !rd.frame_sync |-> ##2 sel.line == $past(sel.line, 2) + 11'h001)
        else $error("line did not step by one");
    a_level_normal:
        assert property (reset_strobe |=> pix_reset_level == issfs_pkg::ISSFS_RST_NORMAL) else $error("bad level");
    a_level_dual:
        assert property (dual_slope_reset && !reset_strobe |=> pix_reset_level == issfs_pkg::ISSFS_RST_DUAL)
        else $error("bad dual level");
    a_readout_held:
        assert property (!memory_boost_strobe |=> !readout_enable) else $error("readout during boost");
    a_readout_opens:
        assert property ($rose(memory_boost_strobe) |-> ##[1:2] readout_enable) else $error("readout late");
    a_integ_window:
        assert property ($fell(reset_strobe) && sample_n |=> integrating) else $error("integration not open");
    a_col_start:
        assert property ($rose(sel.active) |-> sel.col_a == {cfg_q.x_start, 1'h0}) else $error("bad first column");
    a_dual_pair:
        assert property (sel.active && cfg_q.dual_out && !$past(cfg_load) |-> sel.col_b == sel.col_a + 11'h001)
        else $error("bad pair");
endmodule : issfs_props

// ---- test/test_image_sensor_frame_sequencer.sv ----
// self-checking bench for the frame sequencer
module test_image_sensor_frame_sequencer;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'h0;
    logic rst_n = 1'h0;
    logic cfg_load = 1'h0;
    issfs_pkg::issfs_cfg_t cfg = '0;
    issfs_pkg::issfs_rd_t rd;
    logic reset_strobe, dual_slope_reset, memory_boost_strobe, sample_n, readout_enable, integrating;
    issfs_pkg::issfs_sel_t sel;
    issfs_pkg::issfs_rst_lvl_t pix_reset_level;
    int bad_count = 0;
    int n_checks = 0;
    int n_cyc = 0;
    // rows: start line, start column, dual output, line steps
    typedef struct {logic [9:0] y; logic [9:0] x; logic d; int n;} issfs_row_t;
    issfs_row_t rows[4] = '{'{10'h000, 10'h000, 1'h0, 1}, '{10'h001, 10'h001, 1'h1, 3},
        '{10'h3ff, 10'h3ff, 1'h0, 2}, '{10'h155, 10'h0aa, 1'h1, 0}};
    always #2.5 clk = ~clk;
    issfs_seq DUT (.clk(clk), .rst_n(rst_n), .cfg(cfg), .cfg_load(cfg_load), .rd(rd),
        .reset_strobe(reset_strobe), .dual_slope_reset(dual_slope_reset), .memory_boost_strobe(memory_boost_strobe),
        .sample_n(sample_n), .sel(sel), .pix_reset_level(pix_reset_level), .readout_enable(readout_enable),
        .integrating(integrating));
    issfs_ctl_model ctl (.clk(clk), .rd(rd), .reset_strobe(reset_strobe), .dual_slope_reset(dual_slope_reset),
        .memory_boost_strobe(memory_boost_strobe), .sample_n(sample_n));
    ////////////////////////////////////////////////////////////////
    task automatic chk_val(input string what, input logic [10:0] exp, input logic [10:0] got);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_val
    task automatic load(input logic [9:0] y, input logic [9:0] x, input logic d);
        cfg = '{dual_out: d, x_start: x, y_start: y};
        cfg_load = 1'h1;
        @(negedge clk);
        cfg_load = 1'h0;
    endtask : load
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : report_and_stop
    // a hang counts as a mismatch; the whole run needs about 1850 cycles
    always @(posedge clk) begin
        n_cyc <= n_cyc + 1;
        if (n_cyc == 20000) begin
            bad_count++;
            report_and_stop();
        end
    end
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(negedge clk);
        chk_val("line in reset", 11'h000, sel.line);
        rst_n = 1'h1;
        @(negedge clk);
        chk_val("readout idle", 11'h000, 11'(readout_enable));
        foreach (rows[i]) begin
            load(rows[i].y, rows[i].x, rows[i].d);
            ctl.frame_start();
            chk_val("start line", {rows[i].y, 1'h0}, sel.line);
            repeat (rows[i].n) ctl.line_step();
            chk_val("line", 11'({rows[i].y, 1'h0} + rows[i].n), sel.line);
            ctl.line_start();
            chk_val("col", {rows[i].x, 1'h0}, sel.col_a);
            chk_val("active", 11'h001, 11'(sel.active));
            chk_val("col b", 11'({rows[i].x, 1'h0} + rows[i].d), sel.col_b);
            ctl.pix_half();
            chk_val("col low", 11'({rows[i].x, 1'h0} + !rows[i].d), sel.col_a);
            ctl.pix_half();
            chk_val("col period", 11'({rows[i].x, 1'h0} + 2), sel.col_a);
            chk_val("col b period", 11'({rows[i].x, 1'h0} + 2 + rows[i].d), sel.col_b);
        end
        // start field changed without its load strobe, then an early sync
        load(10'h005, 10'h000, 1'h0);
        cfg.y_start = 10'h0f0;
        ctl.frame_start();
        repeat (3) ctl.line_step();
        ctl.frame_start();
        chk_val("restart", 11'h00a, sel.line);
        for (int k = 0; k < 4; k++) begin
            ctl.set_rst(k[1], k[0]);
            chk_val("level", 11'(k[1] ? 1 : (k[0] ? 2 : 0)), 11'(pix_reset_level));
        end
        ctl.expose();
        chk_val("integrating", 11'h001, 11'(integrating));
        ctl.store();
        chk_val("closed", 11'h000, 11'(integrating));
        chk_val("readout", 11'h001, 11'(readout_enable));
        rst_n = 1'h0;
        @(negedge clk);
        chk_val("readout in reset", 11'h000, 11'(readout_enable));
        rst_n = 1'h1;
        repeat (2) @(negedge clk);
        chk_val("readout after reset", 11'h000, 11'(readout_enable));
        chk_val("line after reset", 11'h000, sel.line);
        report_and_stop();
    end
endmodule : test_image_sensor_frame_sequencer

bind issfs_seq issfs_props u_props (.clk(clk), .rst_n(rst_n), .cfg(cfg), .cfg_load(cfg_load), .rd(rd),
    .reset_strobe(reset_strobe), .dual_slope_reset(dual_slope_reset), .memory_boost_strobe(memory_boost_strobe),
    .sample_n(sample_n), .sel(sel), .pix_reset_level(pix_reset_level), .readout_enable(readout_enable),
    .integrating(integrating));

// ---- verilog/issfs_edge.sv ----
// edge detector for controller strobes sampled on clk
module issfs_edge #(
    parameter int WIDTH = 4
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] level,
    output logic [WIDTH-1:0] rise,
    output logic [WIDTH-1:0] fall
);
    logic [WIDTH-1:0] level_q;

    // elaboration check: a zero width leaves nothing to detect
    if (WIDTH < 1) begin : g_bad_width
        $error("issfs_edge: WIDTH must be at least 1");
    end

    // remember last level; inputs are already synchronous
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            level_q <= '0;
        end else begin
            level_q <= level;
        end
    end

    // per-bit edge pulses
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_edge
            assign rise[i] = level[i] & ~level_q[i];
            assign fall[i] = ~level[i] & level_q[i];
        end
    endgenerate
endmodule : issfs_edge

// ---- verilog/issfs_pkg.sv ----
// package: constants and carrier types for the image sensor frame sequencer
package issfs_pkg;
    // address widths
    localparam int ADDR_W = 10;
    localparam int LINE_W = ADDR_W + 1;
    // start address is the configured value times two
    localparam int START_SHIFT = 1;
    // reset values
    localparam logic [LINE_W-1:0] LINE_RST = 11'h000;
    // clock figures
    localparam int CLK_PERIOD_PS = 5000;
    // frame sync least width, in ns as printed
    localparam int FSYNC_MIN_NS = 20;
    localparam int FSYNC_MIN_CYC = ((FSYNC_MIN_NS * 1000) + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // readout configuration word fields used by this block
    typedef struct packed {
        logic dual_out;
        logic [ADDR_W-1:0] x_start;
        logic [ADDR_W-1:0] y_start;
    } issfs_cfg_t;

    // readout control strobes from the controller
    typedef struct packed {
        logic frame_sync;
        logic line_clk;
        logic line_sync;
        logic pix_clk;
    } issfs_rd_t;

    // pixel array strobes from the controller
    typedef struct packed {
        logic reset_n_lvl;
        logic reset_strobe;
        logic dual_slope_reset;
        logic sample_n;
        logic precharge_n;
        logic memory_boost_strobe;
    } issfs_pix_t;

    // selection presented to the array and output multiplexer
    typedef struct packed {
        logic [LINE_W-1:0] line;
        logic [LINE_W-1:0] col_a;
        logic [LINE_W-1:0] col_b;
        logic active;
    } issfs_sel_t;

    // pixel reset level choice
    typedef enum logic [1:0] {
        ISSFS_RST_NONE = 2'b00,
        ISSFS_RST_NORMAL = 2'b01,
        ISSFS_RST_DUAL = 2'b10
    } issfs_rst_lvl_t;
endpackage : issfs_pkg

// ---- verilog/issfs_seq.sv ----
// image sensor frame sequencer: line and column selection and pixel reset level
module issfs_seq #(
    parameter int ADDR_W = issfs_pkg::ADDR_W
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire issfs_pkg::issfs_cfg_t cfg,
    input wire logic cfg_load,
    input wire issfs_pkg::issfs_rd_t rd,
    input wire logic reset_strobe,
    input wire logic dual_slope_reset,
    input wire logic memory_boost_strobe,
    input wire logic sample_n,
    output issfs_pkg::issfs_sel_t sel,
    output issfs_pkg::issfs_rst_lvl_t pix_reset_level,
    output logic readout_enable,
    output logic integrating
);
    localparam int LW = ADDR_W + 1;

    ////////////////////////////////////////////////////////////////////////////
    // scope: this block only sequences addresses, the pixel reset level, the integration window and the readout enable;
    // the column sample-and-hold, row deselect and precharge strobes pass straight
    // from the controller to the array and are not timed here, so their widths
    // stay the controller's business
    ////////////////////////////////////////////////////////////////////////////
    // elaboration check: the start fields come from the shared configuration
    // word, so a different address width would slice them wrongly
    if (ADDR_W != issfs_pkg::ADDR_W) begin : g_bad_addr_w
        $error("issfs_seq: ADDR_W must match the configuration word");
    end

    ////////////////////////////////////////////////////////////////////////////
    // strobe edges
    logic [3:0] lvl;
    logic [3:0] rise;
    logic [3:0] fall;
    // the boost strobe is active low and idles high; it enters the detector
    // inverted so that the detector's cleared history matches the idle level,
    // otherwise the first edge after reset would look like a boost release
    logic boost_act;
    assign boost_act = ~memory_boost_strobe;
    assign lvl = {rd.line_clk, rd.pix_clk, reset_strobe, boost_act};

    issfs_edge #(
        .WIDTH(4)
    ) u_edge (
        .clk(clk),
        .rst_n(rst_n),
        .level(lvl),
        .rise(rise),
        .fall(fall)
    );

    logic line_rise;
    logic pix_rise;
    logic pix_fall;
    logic rst_fall;
    logic boost_rise;
    assign line_rise = rise[3];
    assign pix_rise = rise[2];
    assign pix_fall = fall[2];
    assign rst_fall = fall[1];
    assign boost_rise = fall[0]; // boost released: its active level ends

    ////////////////////////////////////////////////////////////////////////////
    // start addresses held from the configuration word
    logic [ADDR_W-1:0] y_start_q;
    logic [ADDR_W-1:0] x_start_q;
    logic dual_out_q;

    // start values only act at the next frame or line sync; the output count
    // switches at once, so the controller loads it between lines
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            y_start_q <= '0;
            x_start_q <= '0;
            dual_out_q <= 1'b0;
        end else if (cfg_load) begin
            y_start_q <= cfg.y_start;
            x_start_q <= cfg.x_start;
            dual_out_q <= cfg.dual_out;
        end
    end

    logic [LW-1:0] y_base;
    logic [LW-1:0] x_base;
    assign y_base = {y_start_q, 1'b0};
    assign x_base = {x_start_q, 1'b0};

    ////////////////////////////////////////////////////////////////////////////
    // line address: frame sync wins over the line clock
    // a sync before the last line simply restarts the frame; the rest is unread
    logic [LW-1:0] line_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            line_q <= issfs_pkg::LINE_RST;
        end else if (rd.frame_sync) begin
            line_q <= y_base;
        end else if (line_rise) begin
            line_q <= line_q + LW'(1);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // column selection: armed by line sync, started by a pixel clock rise
    logic armed_q;
    logic active_q;
    logic [LW-1:0] col_q;

    // a new line clock drops the column output so the old level is held
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            armed_q <= 1'b0;
            active_q <= 1'b0;
        end else if (rd.frame_sync || line_rise) begin
            armed_q <= 1'b0;
            active_q <= 1'b0;
        end else if (rd.line_sync) begin
            armed_q <= 1'b1;
            if (pix_rise) begin
                active_q <= 1'b1;
            end
        end else if (armed_q && pix_rise) begin
            active_q <= 1'b1;
        end
    end

    // column step: two pixels per clock period, on each phase with one output;
    // with two outputs the pair advances on the rise only, col_b one above col_a
    // limitation: no end-of-line stop, the controller closes the window itself
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            col_q <= issfs_pkg::LINE_RST;
        end else if (rd.line_sync && !active_q) begin
            col_q <= x_base;
        end else if (active_q) begin
            if (dual_out_q) begin
                if (pix_rise) begin
                    col_q <= col_q + LW'(2);
                end
            end else if (pix_rise || pix_fall) begin
                col_q <= col_q + LW'(1);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // selection outputs registered; col_b is the second output's pixel
    // registering costs a cycle but keeps the address lines free of glitches
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sel <= '0;
        end else begin
            sel.line <= line_q;
            sel.col_a <= col_q;
            sel.col_b <= dual_out_q ? col_q + LW'(1) : col_q;
            sel.active <= active_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pixel reset level: normal reset dominates the dual-slope level
    // the dual-slope level only applies while the normal reset is idle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pix_reset_level <= issfs_pkg::ISSFS_RST_NONE;
        end else if (reset_strobe) begin
            pix_reset_level <= issfs_pkg::ISSFS_RST_NORMAL;
        end else if (dual_slope_reset) begin
            pix_reset_level <= issfs_pkg::ISSFS_RST_DUAL;
        end else begin
            pix_reset_level <= issfs_pkg::ISSFS_RST_NONE;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // integration window: reset falling until sample goes active (low)
    // a longer reset pulse moves the opening later and so shortens the window
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            integrating <= 1'b0;
        end else if (!sample_n) begin
            integrating <= 1'b0;
        end else if (rst_fall) begin
            integrating <= 1'b1;
        end
    end

    // readout is allowed once the boost strobe returns high (inactive); the
    // low time of the boost strobe is the frame overhead, so readout stays shut
    // for all of it even if a line clock arrives early
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            readout_enable <= 1'b0;
        end else if (!memory_boost_strobe) begin
            readout_enable <= 1'b0;
        end else if (boost_rise) begin
            readout_enable <= 1'b1;
        end
    end
endmodule : issfs_seq
